/* src/dsp_xfer_pkg.sv */
// Purpose: constants shared by the DSP control and transfer decoder
// Assumes: 10 MHz clk, Avalon-MM register window with byte addresses
// Notes: instruction patterns, register ids, bus offsets and cycle counts
`default_nettype none
package dsp_xfer_pkg;
   // register window byte offsets
   localparam logic [7:0] OFF_INSTR = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_PC = 8'h08;
   localparam logic [7:0] OFF_SR = 8'h0c;
   localparam logic [7:0] OFF_SREG_BASE = 8'h40;
   localparam logic [7:0] OFF_SREG_LAST = 8'hbc;
   localparam logic [7:0] OFF_GREG_BASE = 8'hc0;
   // status field positions
   localparam int STAT_BUSY = 0;
   localparam int STAT_ILLEGAL = 1;
   // reset values
   localparam logic [31:0] PC_RST = 32'h0000_0000;
   localparam logic [31:0] SR_RST = 32'h0000_0000;
   localparam logic [31:0] REG_RST = 32'h0000_0000;
   // repeat_count field of cpu_status_word
   localparam int RC_LO = 16;
   localparam int RC_HI = 27;
   // instruction patterns
   localparam logic [7:0] OP_SET_REPEAT_COUNT_OP_IMM = 8'h82;
   localparam logic [7:0] OP_SET_REPEAT_COUNT_OP_REG = 8'h14;
   localparam logic [7:0] OP_LD_START = 8'h8c;
   localparam logic [7:0] OP_LD_END = 8'h8e;
   localparam logic [3:0] GRP_MOVE = 4'h0;
   localparam logic [3:0] GRP_LDST = 4'h4;
   localparam logic [5:0] GRP_DOUBLE = 6'h3c;
   localparam logic [5:0] GRP_SINGLE = 6'h3d;
   localparam logic [3:0] LO_STC = 4'h2;
   localparam logic [3:0] LO_STS = 4'ha;
   localparam logic [3:0] LO_STS_L = 4'h2;
   localparam logic [3:0] LO_STC_L = 4'h3;
   localparam logic [3:0] LO_LDS_L = 4'h6;
   localparam logic [3:0] LO_LDC_L = 4'h7;
   localparam logic [3:0] LO_LDS = 4'ha;
   localparam logic [3:0] LO_LDC = 4'he;
   localparam logic [3:0] SYS_FIRST = 4'h6;
   localparam logic [3:0] SYS_LAST = 4'hb;
   localparam logic [3:0] CTL_FIRST = 4'h5;
   localparam logic [3:0] CTL_LAST = 4'h7;
   // cycle counts
   localparam logic [1:0] CYC_SET_REPEAT_COUNT_OP = 2'h3;
   localparam logic [1:0] CYC_PCREL = 2'h3;
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_STC_L = 2'h2;
   localparam logic [1:0] CYC_LDC = 2'h3;
   localparam logic [1:0] CYC_LOAD_MIN = 2'h2;
   // pointer steps
   localparam logic [31:0] STEP_WORD = 32'h0000_0002;
   localparam logic [31:0] STEP_LONG = 32'h0000_0004;
   // general register numbers with fixed roles
   localparam logic [3:0] GR_X_INDEX = 4'h8;
   localparam logic [3:0] GR_Y_INDEX = 4'h9;
   localparam logic [2:0] GR_X_PTR_HI = 3'h2;
   localparam logic [2:0] GR_Y_PTR_HI = 3'h3;
   // system register ids (low nibble equals the data-register operand code)
   localparam logic [4:0] ID_FIRST = 5'h05;
   localparam logic [4:0] ID_A1 = 5'h05;
   localparam logic [4:0] ID_DSR = 5'h06;
   localparam logic [4:0] ID_A0 = 5'h07;
   localparam logic [4:0] ID_X0 = 5'h08;
   localparam logic [4:0] ID_X1 = 5'h09;
   localparam logic [4:0] ID_Y0 = 5'h0a;
   localparam logic [4:0] ID_Y1 = 5'h0b;
   localparam logic [4:0] ID_M0 = 5'h0c;
   localparam logic [4:0] ID_G1 = 5'h0d;
   localparam logic [4:0] ID_M1 = 5'h0e;
   localparam logic [4:0] ID_G0 = 5'h0f;
   localparam logic [4:0] ID_MOD = 5'h10;
   localparam logic [4:0] ID_RS = 5'h11;
   localparam logic [4:0] ID_RE = 5'h12;
endpackage
`default_nettype wire

/* src/dsp_ctrl_xfer_decode.sv */
// Purpose: decode and execute system-control and DSP transfer instructions
// Assumes: memories answer a read one cycle after the request cycle
// Notes: one instruction at a time is issued by writing the instruction register
//
// Functional notes
// - immediate repeat-count set writes imm to bits 23:16, clears 27:24
// - register repeat-count set copies general_reg_n 11:0 into bits 27:16
// - repeat-count set has two encodings, 3 cycles, T bit untouched
// - repeat_start/repeat_end loadable by control loads or PC-relative loads, 3 cycles
// - every instruction handled here is one 16-bit word
// - modulo_control, repeat_start, repeat_end copy to general_reg_n in 1 cycle
// - DSP system registers copy to general_reg_n in 1 cycle
// - predecrement long store of DSP system register: minus 4 then store
// - predecrement long store of control register: minus 4, store, 2 cycles
// - postincrement long load of DSP system register: load then plus 4
// - postincrement long load of control register, plus 4, 3 cycles
// - general_reg_n copies into DSP system registers in 1 cycle
// - general_reg_n copies into control registers in 3 cycles
// - double transfer: X and Y access in parallel, each with own pointer
// - double transfers reach on-chip X/Y only; single reaches whole space
// - no conditional loads in the 16-bit transfer forms
// - single word transfer moves upper half; update -2, none, +2, +x_index
// - single long transfer moves 32 bits; update -4, none, +4, +x_index
// - guard byte word store drives byte on bits 7:0, sign on 31:8
// - only permitted general registers serve as pointers and indexes
`default_nettype none
module dsp_ctrl_xfer_decode
   import dsp_xfer_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic sys_req,
   output logic sys_we,
   output logic sys_long,
   output logic [31:0] sys_addr,
   output logic [31:0] load_data_bus,
   input wire logic [31:0] sys_rdata,
   output logic x_req,
   output logic x_we,
   output logic [15:0] x_addr,
   output logic [15:0] x_wdata,
   input wire logic [15:0] x_rdata,
   output logic y_req,
   output logic y_we,
   output logic [15:0] y_addr,
   output logic [15:0] y_wdata,
   input wire logic [15:0] y_rdata,
   output logic illegal_op
);

   logic [31:0] gr_r [0:15];
   logic [31:0] sreg_r [0:31];
   logic [31:0] sr_r;
   logic [31:0] pc_r;
   logic [15:0] ir_r;
   logic [1:0] cnt_r;
   logic illegal_r;
   logic rd_done_r;
   logic busy;
   logic issue;
   logic [15:0] iw;

   // load writeback pipeline: stage one is the request cycle, stage two the data cycle
   logic ps_r, px_r, py_r;
   logic qs_r, qx_r, qy_r;
   logic [4:0] s_id_r, x_id_r, y_id_r;
   logic s_word_r;

   // decoder results
   logic ok;
   logic [1:0] cyc;
   logic ga_we, gb_we;
   logic [3:0] ga_idx, gb_idx;
   logic [31:0] ga_val, gb_val;
   logic rc_we;
   logic [11:0] rc_val;
   logic si_we;
   logic [4:0] si_id;
   logic [31:0] si_val;
   logic s_req, s_we, s_long, s_ld, s_word;
   logic [31:0] s_addr, s_data;
   logic [4:0] s_id, x_id, y_id;
   logic xq, xw, yq, yw;
   logic [15:0] xa, xd, ya, yd;

   function automatic logic in_range(input logic [3:0] v, input logic [3:0] lo,
                                     input logic [3:0] hi);
      return (v >= lo) && (v <= hi);
   endfunction

   function automatic logic [4:0] ctl_id(input logic [3:0] hi);
      return ID_MOD + {3'h0, hi[1:0] - CTL_FIRST[1:0]};
   endfunction

   function automatic logic is_guard(input logic [4:0] id);
      return (id == ID_G0) || (id == ID_G1);
   endfunction

   // pointer update code: 00 predecrement, 01 keep, 10 postincrement, 11 plus index
   function automatic logic [31:0] upd(input logic [31:0] p, input logic [1:0] op,
                                       input logic [31:0] step, input logic [31:0] idx);
      logic [31:0] r;
      r = p;
      unique case (op)
         2'b00: r = p - step;
         2'b01: r = p;
         2'b10: r = p + step;
         2'b11: r = p + idx;
      endcase
      return r;
   endfunction

   // data landing in a system register; guard bytes keep only the low byte
   function automatic logic [31:0] wb_val(input logic [4:0] id, input logic [31:0] d,
                                          input logic word);
      logic [31:0] r;
      r = d;
      if (is_guard(id)) begin
         r = {24'h00_0000, d[7:0]};
      end else if (word) begin
         r = {d[15:0], 16'h0000};
      end
      return r;
   endfunction

   assign busy = (cnt_r != 2'h0);
   assign issue = avs_write && !busy && (avs_address == OFF_INSTR);
   assign iw = avs_writedata[15:0];
   // reads always take one wait cycle so readdata comes from a flop
   assign avs_waitrequest = (avs_read && !rd_done_r) || (avs_write && busy);

   always_comb begin
      logic [3:0] n;
      logic [3:0] hi;
      logic [3:0] lo;
      logic [31:0] rn;
      logic [3:0] ap;
      logic [31:0] step;
      logic [4:0] ds;
      n = iw[11:8];
      hi = iw[7:4];
      lo = iw[3:0];
      rn = gr_r[n];
      ap = 4'h0;
      step = STEP_WORD;
      ds = {1'b0, iw[7:4]};
      ok = 1'b1;
      cyc = CYC_ONE;
      ga_we = 1'b0;
      ga_idx = n;
      ga_val = 32'h0000_0000;
      gb_we = 1'b0;
      gb_idx = n;
      gb_val = 32'h0000_0000;
      rc_we = 1'b0;
      rc_val = 12'h000;
      si_we = 1'b0;
      si_id = ID_DSR;
      si_val = rn;
      s_req = 1'b0;
      s_we = 1'b0;
      s_long = 1'b1;
      s_ld = 1'b0;
      s_word = 1'b0;
      s_addr = rn;
      s_data = 32'h0000_0000;
      s_id = ID_DSR;
      xq = 1'b0;
      xw = 1'b0;
      xa = 16'h0000;
      xd = 16'h0000;
      x_id = ID_X0;
      yq = 1'b0;
      yw = 1'b0;
      ya = 16'h0000;
      yd = 16'h0000;
      y_id = ID_Y0;
      // every form below is a single 16-bit word
      if (iw[15:8] == OP_SET_REPEAT_COUNT_OP_IMM) begin
         cyc = CYC_SET_REPEAT_COUNT_OP;
         rc_we = 1'b1;
         rc_val = {4'h0, iw[7:0]};
      end else if (iw[15:12] == GRP_LDST && iw[7:0] == OP_SET_REPEAT_COUNT_OP_REG) begin
         cyc = CYC_SET_REPEAT_COUNT_OP;
         rc_we = 1'b1;
         rc_val = rn[11:0];
      end else if (iw[15:8] == OP_LD_START || iw[15:8] == OP_LD_END) begin
         cyc = CYC_PCREL;
         s_req = 1'b1;
         s_ld = 1'b1;
         s_addr = pc_r + {23'h00_0000, iw[7:0], 1'b0};
         s_id = (iw[9] ? ID_RE : ID_RS);
      end else if (iw[15:12] == GRP_MOVE && lo == LO_STC && in_range(hi, CTL_FIRST, CTL_LAST)) begin
         ga_we = 1'b1;
         ga_val = sreg_r[ctl_id(hi)];
      end else if (iw[15:12] == GRP_MOVE && lo == LO_STS && in_range(hi, SYS_FIRST, SYS_LAST)) begin
         ga_we = 1'b1;
         ga_val = sreg_r[ds];
      end else if (iw[15:12] == GRP_LDST && lo == LO_STS_L && in_range(hi, SYS_FIRST, SYS_LAST)) begin
         ga_we = 1'b1;
         ga_val = rn - STEP_LONG;
         s_req = 1'b1;
         s_we = 1'b1;
         s_addr = rn - STEP_LONG;
         s_data = sreg_r[ds];
      end else if (iw[15:12] == GRP_LDST && lo == LO_STC_L && in_range(hi, CTL_FIRST, CTL_LAST)) begin
         cyc = CYC_STC_L;
         ga_we = 1'b1;
         ga_val = rn - STEP_LONG;
         s_req = 1'b1;
         s_we = 1'b1;
         s_addr = rn - STEP_LONG;
         s_data = sreg_r[ctl_id(hi)];
      end else if (iw[15:12] == GRP_LDST && lo == LO_LDS_L && in_range(hi, SYS_FIRST, SYS_LAST)) begin
         ga_we = 1'b1;
         ga_val = rn + STEP_LONG;
         s_req = 1'b1;
         s_ld = 1'b1;
         s_id = ds;
      end else if (iw[15:12] == GRP_LDST && lo == LO_LDC_L && in_range(hi, CTL_FIRST, CTL_LAST)) begin
         cyc = CYC_LDC;
         ga_we = 1'b1;
         ga_val = rn + STEP_LONG;
         s_req = 1'b1;
         s_ld = 1'b1;
         s_id = ctl_id(hi);
      end else if (iw[15:12] == GRP_LDST && lo == LO_LDS && in_range(hi, SYS_FIRST, SYS_LAST)) begin
         si_we = 1'b1;
         si_id = ds;
      end else if (iw[15:12] == GRP_LDST && lo == LO_LDC && in_range(hi, CTL_FIRST, CTL_LAST)) begin
         cyc = CYC_LDC;
         si_we = 1'b1;
         si_id = ctl_id(hi);
      end else if (iw[15:10] == GRP_DOUBLE) begin
         // both sides may fire in the same cycle; neither looks at the other
         ga_idx = {GR_X_PTR_HI, iw[9]};
         gb_idx = {GR_Y_PTR_HI, iw[8]};
         if (iw[3:2] != 2'b00) begin
            xq = 1'b1;
            xw = iw[5];
            xa = gr_r[ga_idx][15:0];
            xd = (iw[7] ? sreg_r[ID_A1][31:16] : sreg_r[ID_A0][31:16]);
            x_id = (iw[7] ? ID_X1 : ID_X0);
            ga_we = 1'b1;
            ga_val = upd(gr_r[ga_idx], iw[3:2], STEP_WORD, gr_r[GR_X_INDEX]);
         end
         if (iw[1:0] != 2'b00) begin
            yq = 1'b1;
            yw = iw[4];
            ya = gr_r[gb_idx][15:0];
            yd = (iw[6] ? sreg_r[ID_A1][31:16] : sreg_r[ID_A0][31:16]);
            y_id = (iw[6] ? ID_Y1 : ID_Y0);
            gb_we = 1'b1;
            gb_val = upd(gr_r[gb_idx], iw[1:0], STEP_WORD, gr_r[GR_Y_INDEX]);
         end
      end else if (iw[15:10] == GRP_SINGLE && ds >= ID_FIRST && ds != ID_DSR) begin
         // pointer code 00..11 picks R4, R5, R2, R3; the Y pointers cannot be named
         ap = (iw[9] ? {3'h1, iw[8]} : {3'h2, iw[8]});
         step = (iw[1] ? STEP_LONG : STEP_WORD);
         ga_idx = ap;
         ga_we = (iw[3:2] != 2'b01);
         ga_val = upd(gr_r[ap], iw[3:2], step, gr_r[GR_X_INDEX]);
         s_req = 1'b1;
         s_long = iw[1];
         s_we = iw[0];
         s_ld = !iw[0];
         s_word = !iw[1];
         s_id = ds;
         s_addr = (iw[3:2] == 2'b00) ? gr_r[ap] - step : gr_r[ap];
         if (is_guard(ds)) begin
            s_data = {{24{sreg_r[ds][7]}}, sreg_r[ds][7:0]};
         end else if (iw[1]) begin
            s_data = sreg_r[ds];
         end else begin
            s_data = {16'h0000, sreg_r[ds][31:16]};
         end
      end else begin
         ok = 1'b0;
      end
   end

   // busy counter; a load waits at least until its data cycle has passed
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= 2'h0;
      end else if (issue) begin
         if ((s_ld || (xq && !xw) || (yq && !yw)) && cyc < CYC_LOAD_MIN) begin
            cnt_r <= CYC_LOAD_MIN;
         end else begin
            cnt_r <= cyc;
         end
      end else if (busy) begin
         cnt_r <= cnt_r - 2'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ir_r <= 16'h0000;
         illegal_r <= 1'b0;
         illegal_op <= 1'b0;
      end else begin
         illegal_op <= issue && !ok;
         if (issue) begin
            ir_r <= iw;
         end
         if (issue && !ok) begin
            illegal_r <= 1'b1;
         end else if (avs_write && !busy && avs_address == OFF_STATUS
                      && avs_writedata[STAT_ILLEGAL]) begin
            illegal_r <= 1'b0;
         end
      end
   end

   // memory request outputs stand for the one cycle after issue
   always_ff @(posedge clk) begin
      if (rst) begin
         sys_req <= 1'b0;
         sys_we <= 1'b0;
         sys_long <= 1'b0;
         sys_addr <= 32'h0000_0000;
         load_data_bus <= 32'h0000_0000;
         x_req <= 1'b0;
         x_we <= 1'b0;
         x_addr <= 16'h0000;
         x_wdata <= 16'h0000;
         y_req <= 1'b0;
         y_we <= 1'b0;
         y_addr <= 16'h0000;
         y_wdata <= 16'h0000;
      end else begin
         sys_req <= issue && ok && s_req;
         sys_we <= issue && ok && s_req && s_we;
         x_req <= issue && ok && xq;
         x_we <= issue && ok && xq && xw;
         y_req <= issue && ok && yq;
         y_we <= issue && ok && yq && yw;
         if (issue && ok) begin
            sys_long <= s_long;
            sys_addr <= s_addr;
            load_data_bus <= s_data;
            x_addr <= xa;
            x_wdata <= xd;
            y_addr <= ya;
            y_wdata <= yd;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ps_r <= 1'b0;
         px_r <= 1'b0;
         py_r <= 1'b0;
         qs_r <= 1'b0;
         qx_r <= 1'b0;
         qy_r <= 1'b0;
         s_id_r <= ID_DSR;
         x_id_r <= ID_X0;
         y_id_r <= ID_Y0;
         s_word_r <= 1'b0;
      end else begin
         ps_r <= issue && ok && s_ld;
         px_r <= issue && ok && xq && !xw;
         py_r <= issue && ok && yq && !yw;
         qs_r <= ps_r;
         qx_r <= px_r;
         qy_r <= py_r;
         if (issue) begin
            s_id_r <= s_id;
            x_id_r <= x_id;
            y_id_r <= y_id;
            s_word_r <= s_word;
         end
      end
   end

   // system, DSP and control registers
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < 32; i++) begin
            sreg_r[i] <= REG_RST;
         end
      end else begin
         if (issue && ok && si_we) begin
            sreg_r[si_id] <= wb_val(si_id, si_val, 1'b0);
         end
         if (qs_r) begin
            sreg_r[s_id_r] <= wb_val(s_id_r, sys_rdata, s_word_r);
         end
         if (qx_r) begin
            sreg_r[x_id_r] <= {x_rdata, 16'h0000};
         end
         if (qy_r) begin
            sreg_r[y_id_r] <= {y_rdata, 16'h0000};
         end
         if (avs_write && !busy && avs_address >= OFF_SREG_BASE
             && avs_address <= OFF_SREG_LAST) begin
            sreg_r[5'((avs_address - OFF_SREG_BASE) >> 2)] <= avs_writedata;
         end
      end
   end

   // general registers: port a serves single pointers and x_pointer, port b y_pointer
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < 16; i++) begin
            gr_r[i] <= REG_RST;
         end
      end else begin
         if (issue && ok && ga_we) begin
            gr_r[ga_idx] <= ga_val;
         end
         if (issue && ok && gb_we) begin
            gr_r[gb_idx] <= gb_val;
         end
         if (avs_write && !busy && avs_address >= OFF_GREG_BASE) begin
            gr_r[avs_address[5:2]] <= avs_writedata;
         end
      end
   end

   // only the repeat_count field changes on execution; T bit and the rest are kept
   always_ff @(posedge clk) begin
      if (rst) begin
         sr_r <= SR_RST;
         pc_r <= PC_RST;
      end else begin
         if (issue && ok && rc_we) begin
            sr_r[RC_HI:RC_LO] <= rc_val;
         end else if (avs_write && !busy && avs_address == OFF_SR) begin
            sr_r <= avs_writedata;
         end
         if (avs_write && !busy && avs_address == OFF_PC) begin
            pc_r <= avs_writedata;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_done_r <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end else begin
         rd_done_r <= avs_read && !rd_done_r;
         if (avs_read && !rd_done_r) begin
            if (avs_address == OFF_INSTR) begin
               avs_readdata <= {16'h0000, ir_r};
            end else if (avs_address == OFF_STATUS) begin
               avs_readdata <= {30'h0000_0000, illegal_r, busy};
            end else if (avs_address == OFF_PC) begin
               avs_readdata <= pc_r;
            end else if (avs_address == OFF_SR) begin
               avs_readdata <= sr_r;
            end else if (avs_address >= OFF_GREG_BASE) begin
               avs_readdata <= gr_r[avs_address[5:2]];
            end else if (avs_address >= OFF_SREG_BASE && avs_address <= OFF_SREG_LAST) begin
               avs_readdata <= sreg_r[5'((avs_address - OFF_SREG_BASE) >> 2)];
            end else begin
               avs_readdata <= 32'h0000_0000;
            end
         end
      end
   end

endmodule
`default_nettype wire

/* tb/ctrl_xfer_monitor.sv */
// Purpose: concurrent checks on the decoder ports
// Assumes: one clock, synchronous active-high reset
// Notes: an instruction counts as issued at the edge its INSTR write is taken
`default_nettype none
module ctrl_xfer_checker
   import dsp_xfer_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] avs_address,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest,
   input wire logic sys_req,
   input wire logic sys_we,
   input wire logic sys_long,
   input wire logic [31:0] load_data_bus,
   input wire logic x_req,
   input wire logic y_req,
   input wire logic illegal_op
);
   timeunit 1ns;
   timeprecision 1ns;
   wire logic go = avs_write && !avs_waitrequest && avs_address == OFF_INSTR;
   wire logic [15:0] iw = avs_writedata[15:0];
   wire logic sgl = go && iw[15:10] == GRP_SINGLE;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_single_sys: assert property (
      sgl && iw[7:4] >= 4'h7 |=> sys_req && !x_req && !y_req && sys_long == $past(avs_writedata[1]))
      else $error("single transfer did not use the system bus");
   a_double_xy: assert property (
      go && iw[15:10] == GRP_DOUBLE && iw[3:2] != 2'h0 && iw[1:0] != 2'h0
      |=> x_req && y_req && !sys_req)
      else $error("double transfer not parallel on x and y");
   a_idle_both: assert property (
      go && iw == 16'hf000 |=> (!x_req && !y_req) [*2])
      else $error("idle transfer touched memory");
   a_bad_ds: assert property (
      sgl && iw[7:4] < 4'h5 |=> illegal_op && !sys_req)
      else $error("bad operand not flagged");
   a_guard_sign: assert property (
      sgl && iw[7:4] inside {4'hd, 4'hf} && iw[1:0] == 2'h1
      |=> sys_we && load_data_bus[31:8] == {24{load_data_bus[7]}})
      else $error("guard byte store not sign extended");
   a_ctl_quiet: assert property (
      go && iw[15:12] == GRP_MOVE && iw[3:0] == LO_STC && iw[7:4] inside {[4'h5:4'h7]}
      |=> !sys_req && !x_req && !y_req && !illegal_op)
      else $error("register copy made an access");
   a_pcrel_load: assert property (
      go && iw[15:8] == OP_LD_START |=> sys_req && !sys_we && sys_long)
      else $error("pc relative load missing");
   a_store_long: assert property (
      go && iw[15:12] == GRP_LDST && iw[3:0] == LO_STS_L && iw[7:4] inside {[4'h6:4'hb]}
      |=> sys_req && sys_we && sys_long)
      else $error("long store missing");
   a_illegal_pulse: assert property (
      illegal_op |=> !illegal_op)
      else $error("illegal flag longer than one cycle");
endmodule
`default_nettype wire

/* tb/xy_mem_model.sv */
// Purpose: system, X and Y memories answering the decoder
// Assumes: read data due in the cycle after the request
// Notes: data is derived from the address; outside that cycle the lines toggle
`default_nettype none
module xy_mem_model (
   input wire logic clk,
   input wire logic sys_req,
   input wire logic sys_we,
   input wire logic [31:0] sys_addr,
   output logic [31:0] sys_rdata,
   input wire logic x_req,
   input wire logic x_we,
   input wire logic [15:0] x_addr,
   output logic [15:0] x_rdata,
   input wire logic y_req,
   input wire logic y_we,
   input wire logic [15:0] y_addr,
   output logic [15:0] y_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      sys_rdata = 32'h0;
      x_rdata = 16'h0;
      y_rdata = 16'h0;
   end
   // any 32-bit address is served, the whole space is reachable
   always @(posedge clk) begin
      sys_rdata <= (sys_req && !sys_we) ? {sys_addr[15:0], ~sys_addr[15:0]} : ~sys_rdata;
      x_rdata <= (x_req && !x_we) ? ~x_addr : ~x_rdata;
      y_rdata <= (y_req && !y_we) ? ~y_addr : ~y_rdata;
   end
endmodule
`default_nettype wire

/* tb/dsp_ctrl_xfer_decode_tb_top.sv */
// Purpose: self-checking bench for the decoder
// Assumes: instruction writes stall while busy, reads answer after a wait
// Notes: a write to unmapped 0x10 serves as a barrier behind each table row and after the last back-to-back instruction run
`default_nettype none
module dsp_ctrl_xfer_decode_tb_top
   import dsp_xfer_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [7:0] c; logic [31:0] e;} row_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, sys_addr, load_data_bus, sys_rdata, s_a, s_d, y_cap, r;
   logic avs_waitrequest, sys_req, sys_we, sys_long, x_req, x_we, y_req, y_we, illegal_op;
   logic [15:0] x_addr, x_wdata, x_rdata, y_addr, y_wdata, y_rdata;
   logic [17:0] x_cap;
   int mismatches = 0;
   int n_tests = 0;
   int w, g1, g2, g3;
   row_t rows [29] = '{
      {8'hc4, 32'hfffffabc, 8'hc4, 32'hfffffabc}, {8'h00, 32'h4114, 8'h0c, 32'h0abc0000},
      {8'h00, 32'h8255, 8'h0c, 32'h00550000}, {8'h00, 32'h418a, 8'h60, 32'hfffffabc},
      {8'h00, 32'h038a, 8'hcc, 32'hfffffabc}, {8'h00, 32'h416e, 8'h84, 32'hfffffabc},
      {8'h00, 32'h0562, 8'hd4, 32'hfffffabc}, {8'h00, 32'h4382, 8'hcc, 32'hfffffab8},
      {8'h08, 32'h100, 8'h08, 32'h100}, {8'h00, 32'h8c08, 8'h84, 32'h0110feef},
      {8'h00, 32'h8e04, 8'h88, 32'h0108fef7}, {8'hd0, 32'h1000, 8'hd0, 32'h1000},
      {8'h00, 32'hf48a, 8'h60, 32'h1000efff}, {8'h10, 32'h0, 8'hd0, 32'h1004},
      {8'hd4, 32'h3000, 8'hd4, 32'h3000}, {8'he0, 32'h10, 8'he0, 32'h10},
      {8'h00, 32'hf5ac, 8'h68, 32'hcfff0000}, {8'h10, 32'h0, 8'hd4, 32'h3010},
      {8'h5c, 32'hbeef1234, 8'h5c, 32'hbeef1234}, {8'hd8, 32'h40, 8'hd8, 32'h40},
      {8'h00, 32'hf099, 8'h64, 32'heffb0000}, {8'h10, 32'h0, 8'hd0, 32'h1006},
      {8'h00, 32'hf000, 8'h10, 32'h0}, {8'h00, 32'hf408, 8'h04, 32'h2},
      {8'h04, 32'h2, 8'h04, 32'h0}, {8'h00, 32'h4166, 8'h58, 32'hfabc0543},
      {8'h10, 32'h0, 8'hc4, 32'hfffffac0}, {8'h00, 32'h4177, 8'h88, 32'hfac0053f},
      {8'h10, 32'h0, 8'hc4, 32'hfffffac4}};
   dsp_ctrl_xfer_decode dsp_ctrl_xfer_decode_i (.*);
   xy_mem_model xy_mem_model_i (.*);
   always #50 clk = ~clk;
   always @(posedge clk) begin
      if (sys_req === 1'b1) begin
         s_a <= sys_addr;
         s_d <= load_data_bus;
      end
      if (x_req === 1'b1) x_cap <= {y_we, x_we, x_addr};
      if (y_req === 1'b1) y_cap <= {y_addr, y_wdata};
   end
   task automatic final_report();
      $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // counts edges up to the one where waitrequest is seen low
   task automatic wait_ack(output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 200);
      if (n >= 200) begin
         mismatches++;
         final_report();
      end
   endtask
   // keep holds write high so the next write follows with no idle cycle
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit keep, output int n);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      wait_ack(n);
      if (!keep) begin
         avs_write <= 1'b0;
         @(posedge clk);
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int n;
      avs_address <= a;
      avs_read <= 1'b1;
      wait_ack(n);
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(8'h60, r);
      check(r, REG_RST);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d, 1'b0, w);
         wr(8'h10, 32'h0, 1'b0, w);
         rd(rows[i].c, r);
         check(r, rows[i].e);
      end
      check({14'h0, x_cap}, 32'h21004);
      check(y_cap, 32'h0040beef);
      wr(8'h7c, 32'h80, 1'b0, w);
      wr(8'hc8, 32'h2000, 1'b0, w);
      wr(8'h00, 32'hf6f1, 1'b0, w);
      wr(8'h10, 32'h0, 1'b0, w);
      check(s_a, 32'h1ffe);
      check(s_d, 32'hffffff80);
      wr(8'h00, 32'h8255, 1'b1, w);
      wr(8'h00, 32'h038a, 1'b0, g3);
      wr(8'h00, 32'h038a, 1'b1, w);
      wr(8'h00, 32'h038a, 1'b0, g1);
      wr(8'h00, 32'h4363, 1'b1, w);
      wr(8'h00, 32'h038a, 1'b0, g2);
      wr(8'h10, 32'h0, 1'b0, w);
      check(32'(g3 - g1), 32'h2);
      check(32'(g2 - g1), 32'h1);
      check(s_a, 32'h1000effb);
      check(s_d, 32'h0110feef);
      // a reset once the run has drained behind the barrier must drop the repeat count set above
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(8'h0c, r);
      check(r, SR_RST);
      final_report();
   end
endmodule
bind dsp_ctrl_xfer_decode ctrl_xfer_checker ctrl_xfer_checker_i (
   .clk(clk),
   .rst(rst),
   .avs_address(avs_address),
   .avs_write(avs_write),
   .avs_writedata(avs_writedata),
   .avs_waitrequest(avs_waitrequest),
   .sys_req(sys_req),
   .sys_we(sys_we),
   .sys_long(sys_long),
   .load_data_bus(load_data_bus),
   .x_req(x_req),
   .y_req(y_req),
   .illegal_op(illegal_op)
);
`default_nettype wire
